// ==== core/hvm_pkg.sv ====
// Purpose: shared constants and types for the hv measurement switch control
// Assumes: 32-bit classic wishbone, registers in byte lane 0 of aligned words
// Notes: offsets are byte addresses; reserved bits read as zero
package hvm_pkg;

   // register offsets
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_MODE = 8'h04;
   localparam logic [7:0] OFF_GPIO = 8'h08;
   localparam logic [7:0] OFF_WSRC = 8'h0C;
   localparam logic [7:0] OFF_WPULL = 8'h10;
   localparam logic [7:0] OFF_STAT = 8'h14;
   localparam logic [7:0] OFF_WSTAT = 8'h18;

   // field positions
   localparam int CTRL_MEAS_BIT = 0;
   localparam int CTRL_FOTEST_BIT = 1;
   localparam int GPIO_OUT_BIT = 3;
   localparam int WSRC_SENSE_BIT = 0;
   localparam int STAT_FAULT_BIT = 0;
   localparam int STAT_SWITCH_BIT = 1;
   localparam int WSTAT_A_BIT = 0;
   localparam int WSTAT_B_BIT = 1;
   localparam int WSTAT_LVL_BIT = 2;
   localparam int WSTAT_GLVL_BIT = 3;

   // pin configuration codes
   localparam logic [2:0] GPIO_OFF = 3'h0;
   localparam logic [2:0] GPIO_FO = 3'h1;
   localparam logic [2:0] GPIO_LS = 3'h2;
   localparam logic [2:0] GPIO_WAKE = 3'h3;
   localparam logic [2:0] GPIO_HS = 3'h4;

   // pull codes
   localparam logic [1:0] PULL_DOWN = 2'h1;
   localparam logic [1:0] PULL_UP = 2'h2;

   // mode request codes
   localparam logic [2:0] REQ_NORMAL = 3'h0;
   localparam logic [2:0] REQ_STOP = 3'h1;
   localparam logic [2:0] REQ_SLEEP = 3'h2;
   localparam logic [2:0] REQ_RESTART = 3'h3;

   // reset values
   localparam logic [2:0] GPIO_RST = GPIO_FO;
   localparam logic [3:0] WSRC_RST = 4'h1;
   localparam logic [1:0] WPULL_RST = 2'h0;

   typedef enum logic [4:0] {
      MODE_NORMAL = 5'h01,
      MODE_STOP = 5'h02,
      MODE_SLEEP = 5'h04,
      MODE_RESTART = 5'h08,
      MODE_FAILSAFE = 5'h10
   } hvm_mode_e;

   typedef struct packed {
      logic wr;
      logic [7:0] adr;
      logic [7:0] wdata;
   } hvm_reg_req_s;

   typedef struct packed {
      logic valid;
      logic lvl_sense;
      logic lvl_gpio;
      logic edge_sense;
      logic edge_gpio;
   } hvm_pin_evt_s;

endpackage : hvm_pkg

// ==== core/hvm_wb_slave.sv ====
// Purpose: classic wishbone slave front end for the register file
// Assumes: master holds request until it samples ack
// Notes: ack one cycle after request; write commits at the ack edge
`timescale 1ns/1ns
module hvm_wb_slave (
   input logic clk_i, // system clock
   input logic rst_i, // sync reset, high
   input logic ce_i, // clock enable
   input logic [7:0] wb_adr_i, // byte address
   input logic [31:0] wb_dat_i, // write data
   input logic wb_we_i, // write enable
   input logic [3:0] wb_sel_i, // byte selects
   input logic wb_cyc_i, // cycle
   input logic wb_stb_i, // strobe
   input logic [31:0] rdata_i, // read mux from register file
   output logic wb_ack_o, // acknowledge
   output logic [31:0] wb_dat_o, // read data
   output hvm_pkg::hvm_reg_req_s req_o // write commit to register file
);
   logic ack_q;
   logic [31:0] dat_q;

   // single-cycle ack, dropped the cycle after it was given
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
      end else if (ce_i) begin
         ack_q <= wb_cyc_i & wb_stb_i & ~ack_q;
      end
   end

   // read data captured with the ack; reads have no side effects
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_q <= 32'h0000_0000;
      end else if (ce_i) begin
         if (wb_cyc_i & wb_stb_i & ~ack_q & ~wb_we_i) begin
            dat_q <= rdata_i;
         end else begin
            dat_q <= 32'h0000_0000;
         end
      end
   end

   // commit at the edge where master sees ack; only byte lane 0 holds bits
   always_comb begin
      req_o.wr = wb_cyc_i & wb_stb_i & wb_we_i & ack_q & wb_sel_i[0] & ce_i;
      req_o.adr = wb_adr_i;
      req_o.wdata = wb_dat_i[7:0];
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;

endmodule : hvm_wb_slave

// ==== core/hvm_pin_gate.sv ====
// Purpose: level and edge sensing of the two pins with measurement gating
// Assumes: pin inputs synchronous to clk_i
// Notes: previous level tracks while gated so release makes no false edge
`timescale 1ns/1ns
module hvm_pin_gate (
   input logic clk_i, // system clock
   input logic rst_i, // sync reset, high
   input logic ce_i, // clock enable
   input logic gate_i, // measurement active, block pins
   input logic sense_i, // hv sense input level
   input logic gpio_i, // fail output gpio pin level
   output hvm_pkg::hvm_pin_evt_s evt_o // registered levels and edges
);
   logic sense_prev_q;
   logic gpio_prev_q;
   hvm_pkg::hvm_pin_evt_s evt_q;

   // previous levels for edge detection
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sense_prev_q <= 1'b0;
         gpio_prev_q <= 1'b0;
      end else if (ce_i) begin
         sense_prev_q <= sense_i;
         gpio_prev_q <= gpio_i;
      end
   end

   // gated events: nothing reaches the status logic while measuring
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         evt_q <= '0;
      end else if (ce_i) begin
         evt_q.valid <= ~gate_i;
         evt_q.lvl_sense <= sense_i & ~gate_i;
         evt_q.lvl_gpio <= gpio_i & ~gate_i;
         evt_q.edge_sense <= (sense_i ^ sense_prev_q) & ~gate_i;
         evt_q.edge_gpio <= (gpio_i ^ gpio_prev_q) & ~gate_i;
      end
   end

   assign evt_o = evt_q;

endmodule : hvm_pin_gate

// ==== core/hvm_switch_ctrl.sv ====
// Purpose: hv measurement route switch control with pin and mode handling
// Assumes: classic wishbone master, pins synchronous to clk_i
// Notes: all outputs registered; ce_i low freezes every flip-flop
`timescale 1ns/1ns
module hvm_switch_ctrl (
   input logic clk_i, // 10 MHz system clock
   input logic rst_i, // sync reset, high
   input logic ce_i, // clock enable
   input logic [7:0] wb_adr_i, // byte address
   input logic [31:0] wb_dat_i, // write data
   input logic wb_we_i, // write enable
   input logic [3:0] wb_sel_i, // byte selects
   input logic wb_cyc_i, // cycle
   input logic wb_stb_i, // strobe
   output logic wb_ack_o, // acknowledge
   output logic [31:0] wb_dat_o, // read data
   input logic hv_sense_input_i, // sense pin level
   input logic fail_output_gpio_pin_i, // pin level seen
   output logic fail_output_gpio_pin_o, // pin drive value
   output logic fail_output_gpio_pin_oe_n_o, // pin drive enable, low
   input logic fail_i, // device failure asks fail output
   input logic fail_safe_i, // device enters fail-safe
   output logic measure_route_switch_o, // high closes switch
   output logic sense_pull_up_o, // sense pin pull-up on
   output logic sense_pull_dn_o, // sense pin pull-down on
   output logic gpio_pull_dn_o, // gpio pin pull-down on
   output logic [4:0] mode_o // one-hot device mode
);
   hvm_pkg::hvm_reg_req_s req;
   hvm_pkg::hvm_pin_evt_s evt;
   hvm_pkg::hvm_mode_e mode_q;
   logic [31:0] rdata;
   logic hv_measure_enable_q;
   logic fo_test_q;
   logic [2:0] gpio_cfg_q;
   logic gpio_out_q;
   logic [3:0] wake_source_config_q;
   logic [1:0] wake_pull_config_q;
   logic fault_q;
   logic wake_status_a_q;
   logic wake_status_b_q;
   logic wake_level_status_q;
   logic gpio_level_q;
   logic switch_q;
   logic sense_pu_q;
   logic sense_pd_q;
   logic gpio_pd_q;
   logic pin_o_q;
   logic pin_oe_n_q;
   logic wr_ctrl;
   logic wr_mode;
   logic wr_gpio;
   logic wr_wsrc;
   logic wr_wpull;
   logic wr_stat;
   logic wr_wstat;
   logic meas_refuse;
   logic gpio_refuse;
   logic pin_only_wake;
   logic sleep_refuse;
   logic fault_set;
   logic set_a;
   logic set_b;

   hvm_wb_slave u_bus (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .wb_adr_i(wb_adr_i),
      .wb_dat_i(wb_dat_i),
      .wb_we_i(wb_we_i),
      .wb_sel_i(wb_sel_i),
      .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i),
      .rdata_i(rdata),
      .wb_ack_o(wb_ack_o),
      .wb_dat_o(wb_dat_o),
      .req_o(req)
   );

   hvm_pin_gate u_pins (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .gate_i(hv_measure_enable_q),
      .sense_i(hv_sense_input_i),
      .gpio_i(fail_output_gpio_pin_i),
      .evt_o(evt)
   );

   // write decode
   assign wr_ctrl = req.wr & (req.adr == hvm_pkg::OFF_CTRL);
   assign wr_mode = req.wr & (req.adr == hvm_pkg::OFF_MODE);
   assign wr_gpio = req.wr & (req.adr == hvm_pkg::OFF_GPIO);
   assign wr_wsrc = req.wr & (req.adr == hvm_pkg::OFF_WSRC);
   assign wr_wpull = req.wr & (req.adr == hvm_pkg::OFF_WPULL);
   assign wr_stat = req.wr & (req.adr == hvm_pkg::OFF_STAT);
   assign wr_wstat = req.wr & (req.adr == hvm_pkg::OFF_WSTAT);

   // enabling needs the pin configured off first
   assign meas_refuse = wr_ctrl & req.wdata[hvm_pkg::CTRL_MEAS_BIT] & ~hv_measure_enable_q
      & (gpio_cfg_q != hvm_pkg::GPIO_OFF);
   // any pin config write while measuring is refused
   assign gpio_refuse = wr_gpio & hv_measure_enable_q;

   // only pin wakes left: sleep would never end, so it is refused
   assign pin_only_wake = hv_measure_enable_q
      & (wake_source_config_q[3:1] == 3'h0)
      & (wake_source_config_q[hvm_pkg::WSRC_SENSE_BIT]
         | (gpio_cfg_q == hvm_pkg::GPIO_WAKE));
   assign sleep_refuse = wr_mode & (req.wdata[2:0] == hvm_pkg::REQ_SLEEP)
      & pin_only_wake
      & ((mode_q == hvm_pkg::MODE_NORMAL) | (mode_q == hvm_pkg::MODE_STOP));
   assign fault_set = meas_refuse | gpio_refuse | sleep_refuse;

   // command fault flag, write one to clear; a new fault beats the clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fault_q <= 1'b0;
      end else if (ce_i) begin
         if (fault_set) begin
            fault_q <= 1'b1;
         end else if (wr_stat & req.wdata[hvm_pkg::STAT_FAULT_BIT]) begin
            fault_q <= 1'b0;
         end
      end
   end

   // enable and forced test bits; a refused enable keeps the old value
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         hv_measure_enable_q <= 1'b0;
         fo_test_q <= 1'b0;
      end else if (ce_i) begin
         if (wr_ctrl & ~meas_refuse) begin
            hv_measure_enable_q <= req.wdata[hvm_pkg::CTRL_MEAS_BIT];
         end
         if (wr_ctrl) begin
            fo_test_q <= req.wdata[hvm_pkg::CTRL_FOTEST_BIT];
         end
      end
   end

   // pin configuration, frozen while measuring
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         gpio_cfg_q <= hvm_pkg::GPIO_RST;
         gpio_out_q <= 1'b0;
      end else if (ce_i) begin
         if (wr_gpio & ~gpio_refuse) begin
            gpio_cfg_q <= req.wdata[2:0];
            gpio_out_q <= req.wdata[hvm_pkg::GPIO_OUT_BIT];
         end
      end
   end

   // wake source and pull settings stay writable while measuring
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wake_source_config_q <= hvm_pkg::WSRC_RST;
         wake_pull_config_q <= hvm_pkg::WPULL_RST;
      end else if (ce_i) begin
         if (wr_wsrc) begin
            wake_source_config_q <= req.wdata[3:0];
         end
         if (wr_wpull) begin
            wake_pull_config_q <= req.wdata[1:0];
         end
      end
   end

   // device mode sequencing; fail-safe wins over everything except reset and ce_i low
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mode_q <= hvm_pkg::MODE_NORMAL;
      end else if (ce_i) begin
         if (fail_safe_i) begin
            mode_q <= hvm_pkg::MODE_FAILSAFE;
         end else begin
            case (mode_q)
               hvm_pkg::MODE_NORMAL, hvm_pkg::MODE_STOP: begin
                  if (wr_mode) begin
                     case (req.wdata[2:0])
                        hvm_pkg::REQ_NORMAL: mode_q <= hvm_pkg::MODE_NORMAL;
                        hvm_pkg::REQ_STOP: mode_q <= hvm_pkg::MODE_STOP;
                        hvm_pkg::REQ_SLEEP: begin
                           if (sleep_refuse) begin
                              mode_q <= hvm_pkg::MODE_RESTART;
                           end else begin
                              mode_q <= hvm_pkg::MODE_SLEEP;
                           end
                        end
                        hvm_pkg::REQ_RESTART: mode_q <= hvm_pkg::MODE_RESTART;
                        default: mode_q <= mode_q;
                     endcase
                  end
               end
               hvm_pkg::MODE_SLEEP: begin
                  // a pending wake ends sleep through restart
                  if (wake_status_a_q | wake_status_b_q) begin
                     mode_q <= hvm_pkg::MODE_RESTART;
                  end
               end
               hvm_pkg::MODE_RESTART: mode_q <= hvm_pkg::MODE_NORMAL;
               hvm_pkg::MODE_FAILSAFE: mode_q <= hvm_pkg::MODE_RESTART;
               default: mode_q <= hvm_pkg::MODE_RESTART;
            endcase
         end
      end
   end

   // route switch: closed only with enable set and in normal mode
   // the enable itself is untouched by mode changes
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         switch_q <= 1'b0;
      end else if (ce_i) begin
         switch_q <= hv_measure_enable_q & (mode_q == hvm_pkg::MODE_NORMAL)
            & ~fail_safe_i;
      end
   end

   // pull currents; measuring turns all of them off
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sense_pu_q <= 1'b0;
         sense_pd_q <= 1'b0;
         gpio_pd_q <= 1'b0;
      end else if (ce_i) begin
         sense_pu_q <= ~hv_measure_enable_q & (wake_pull_config_q == hvm_pkg::PULL_UP);
         sense_pd_q <= ~hv_measure_enable_q & (wake_pull_config_q == hvm_pkg::PULL_DOWN);
         gpio_pd_q <= ~hv_measure_enable_q & (gpio_cfg_q == hvm_pkg::GPIO_WAKE);
      end
   end

   // pin drivers; released while measuring so the divider sees the switch
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_o_q <= 1'b0;
         pin_oe_n_q <= 1'b1;
      end else if (ce_i) begin
         pin_o_q <= 1'b0;
         pin_oe_n_q <= 1'b1;
         if (~hv_measure_enable_q) begin
            case (gpio_cfg_q)
               hvm_pkg::GPIO_FO: begin
                  pin_oe_n_q <= ~(fail_i | fo_test_q);
               end
               hvm_pkg::GPIO_LS: begin
                  pin_oe_n_q <= ~gpio_out_q;
               end
               hvm_pkg::GPIO_HS: begin
                  pin_o_q <= 1'b1;
                  pin_oe_n_q <= ~gpio_out_q;
               end
               default: pin_oe_n_q <= 1'b1;
            endcase
         end
      end
   end

   // wake events come through the gate, so measuring blocks new status sets; write one to clear still works
   assign set_a = evt.valid & evt.edge_sense
      & wake_source_config_q[hvm_pkg::WSRC_SENSE_BIT];
   assign set_b = evt.valid & evt.edge_gpio & (gpio_cfg_q == hvm_pkg::GPIO_WAKE);

   // wake status, write one to clear, new events beat the clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wake_status_a_q <= 1'b0;
         wake_status_b_q <= 1'b0;
      end else if (ce_i) begin
         if (set_a) begin
            wake_status_a_q <= 1'b1;
         end else if (wr_wstat & req.wdata[hvm_pkg::WSTAT_A_BIT]) begin
            wake_status_a_q <= 1'b0;
         end
         if (set_b) begin
            wake_status_b_q <= 1'b1;
         end else if (wr_wstat & req.wdata[hvm_pkg::WSTAT_B_BIT]) begin
            wake_status_b_q <= 1'b0;
         end
      end
   end

   // level status holds its last value while measuring
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wake_level_status_q <= 1'b0;
         gpio_level_q <= 1'b0;
      end else if (ce_i) begin
         if (evt.valid) begin
            wake_level_status_q <= evt.lvl_sense;
            gpio_level_q <= evt.lvl_gpio & (gpio_cfg_q == hvm_pkg::GPIO_WAKE);
         end
      end
   end

   // read mux; unmapped addresses read zero
   always_comb begin
      rdata = 32'h0000_0000;
      case (req.adr)
         hvm_pkg::OFF_CTRL: begin
            rdata[hvm_pkg::CTRL_MEAS_BIT] = hv_measure_enable_q;
            rdata[hvm_pkg::CTRL_FOTEST_BIT] = fo_test_q;
         end
         hvm_pkg::OFF_MODE: rdata[4:0] = mode_q;
         hvm_pkg::OFF_GPIO: begin
            rdata[2:0] = gpio_cfg_q;
            rdata[hvm_pkg::GPIO_OUT_BIT] = gpio_out_q;
         end
         hvm_pkg::OFF_WSRC: rdata[3:0] = wake_source_config_q;
         hvm_pkg::OFF_WPULL: rdata[1:0] = wake_pull_config_q;
         hvm_pkg::OFF_STAT: begin
            rdata[hvm_pkg::STAT_FAULT_BIT] = fault_q;
            rdata[hvm_pkg::STAT_SWITCH_BIT] = switch_q;
         end
         hvm_pkg::OFF_WSTAT: begin
            rdata[hvm_pkg::WSTAT_A_BIT] = wake_status_a_q;
            rdata[hvm_pkg::WSTAT_B_BIT] = wake_status_b_q;
            rdata[hvm_pkg::WSTAT_LVL_BIT] = wake_level_status_q;
            rdata[hvm_pkg::WSTAT_GLVL_BIT] = gpio_level_q;
         end
         default: rdata = 32'h0000_0000;
      endcase
   end

   // outputs straight from flip-flops
   assign measure_route_switch_o = switch_q;
   assign sense_pull_up_o = sense_pu_q;
   assign sense_pull_dn_o = sense_pd_q;
   assign gpio_pull_dn_o = gpio_pd_q;
   assign fail_output_gpio_pin_o = pin_o_q;
   assign fail_output_gpio_pin_oe_n_o = pin_oe_n_q;
   assign mode_o = mode_q;

endmodule : hvm_switch_ctrl

// ==== verif/hvm_divider_model.sv ====
// Purpose: far side of the route pin, an external divider into a converter input
// Assumes: divider to ground acts as a weak pull-down on the pin
// Notes: resolves the pin level from device drive, switch and sense input
`timescale 1ns/1ns
module hvm_divider_model (
   input logic switch_i, // route switch closed
   input logic sense_i, // hv sense input level
   input logic drv_i, // device pin drive value
   input logic oe_n_i, // device pin drive enable, low
   output logic pin_o, // resolved pin level
   output logic adc_o // level seen by the converter
);
   // device drive wins; a released pin follows the divider unless the switch routes sense
   assign pin_o = !oe_n_i ? drv_i : (switch_i ? sense_i : 1'b0);
   assign adc_o = pin_o; // converter sits on the divider tap
endmodule : hvm_divider_model

// ==== verif/hvm_switch_ctrl_sva.sv ====
// Purpose: port-level checks of the route switch control
// Assumes: ce_i high while requests are made
// Notes: bound to every hvm_switch_ctrl instance
`timescale 1ns/1ns
module hvm_switch_ctrl_sva (
   input logic clk_i, // clock
   input logic rst_i, // sync reset
   input logic ce_i, // clock enable
   input logic wb_cyc_i, // cycle
   input logic wb_stb_i, // strobe
   input logic wb_ack_o, // acknowledge
   input logic [31:0] wb_dat_o, // read data
   input logic fail_safe_i, // fail-safe request
   input logic fail_output_gpio_pin_oe_n_o, // pin drive enable, low
   input logic measure_route_switch_o, // switch closed
   input logic sense_pull_up_o, // pull-up
   input logic sense_pull_dn_o, // pull-down
   input logic gpio_pull_dn_o, // gpio pull-down
   input logic [4:0] mode_o // one-hot mode
);
   default clocking cb @(posedge clk_i); endclocking
   // new request: ack must come next cycle and last one cycle only
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
   endsequence
   sequence s_ack;
      wb_ack_o ##1 !wb_ack_o;
   endsequence
   property p_reset;
      rst_i && ce_i |=> !measure_route_switch_o && fail_output_gpio_pin_oe_n_o;
   endproperty
   property p_ack;
      disable iff (rst_i) s_req |=> s_ack;
   endproperty
   property p_ack_once;
      disable iff (rst_i) wb_ack_o && ce_i |=> !wb_ack_o;
   endproperty
   property p_rd_zero;
      disable iff (rst_i) !wb_ack_o |-> wb_dat_o == 32'h0;
   endproperty
   // switch may only stay closed one edge past leaving normal mode
   property p_mode;
      disable iff (rst_i) ce_i && mode_o != 5'h01 |=> !measure_route_switch_o;
   endproperty
   property p_failsafe;
      disable iff (rst_i) ce_i && fail_safe_i |=> !measure_route_switch_o && mode_o == 5'h10;
   endproperty
   property p_pulls;
      disable iff (rst_i)
         measure_route_switch_o |-> !sense_pull_up_o && !sense_pull_dn_o && !gpio_pull_dn_o;
   endproperty
   property p_pin;
      disable iff (rst_i) measure_route_switch_o |-> fail_output_gpio_pin_oe_n_o;
   endproperty
   a_reset: assert property (p_reset) else $error("outputs not off after reset");
   a_ack: assert property (p_ack) else $error("ack missing or too long");
   a_ack_once: assert property (p_ack_once) else $error("ack longer than one cycle");
   a_rd_zero: assert property (p_rd_zero) else $error("read data outside ack");
   a_mode: assert property (p_mode) else $error("switch closed outside normal");
   a_failsafe: assert property (p_failsafe) else $error("switch closed in fail-safe");
   a_pulls: assert property (p_pulls) else $error("pull on while measuring");
   a_pin: assert property (p_pin) else $error("pin driven while measuring");
endmodule : hvm_switch_ctrl_sva
bind hvm_switch_ctrl hvm_switch_ctrl_sva u_sva (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
   .fail_safe_i(fail_safe_i), .fail_output_gpio_pin_oe_n_o(fail_output_gpio_pin_oe_n_o),
   .measure_route_switch_o(measure_route_switch_o), .sense_pull_up_o(sense_pull_up_o),
   .sense_pull_dn_o(sense_pull_dn_o), .gpio_pull_dn_o(gpio_pull_dn_o), .mode_o(mode_o));

// ==== verif/tb.sv ====
// Purpose: self-checking bench for the route switch control
// Assumes: ack arrives within a few cycles of a request
// Notes: reset and fail output checks, then register rows, then fail-safe and other cases by hand
`timescale 1ns/1ns
module tb;
   typedef struct packed {
      logic sense;
      logic we;
      logic [7:0] adr;
      logic [7:0] wd;
      logic [7:0] mask;
      logic [7:0] exp;
   } hvm_row_s;
   logic clk_i, rst_i, cyc, stb, we, ack, oe_n, pin_o, pin_i, sense, sw, fail, fsafe;
   logic pu, pd, gpd, ce;
   logic [7:0] adr;
   logic [31:0] wdat, rdat, rd;
   logic [4:0] mode;
   int errors = 0;
   int samples_checked = 0;
   int cycles = 0;
   int n;
   hvm_row_s rows [30];

   hvm_switch_ctrl DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_adr_i(adr),
      .wb_dat_i(wdat), .wb_we_i(we), .wb_sel_i(4'hF), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_ack_o(ack), .wb_dat_o(rdat), .hv_sense_input_i(sense),
      .fail_output_gpio_pin_i(pin_i), .fail_output_gpio_pin_o(pin_o),
      .fail_output_gpio_pin_oe_n_o(oe_n), .fail_i(fail), .fail_safe_i(fsafe),
      .measure_route_switch_o(sw), .sense_pull_up_o(pu), .sense_pull_dn_o(pd),
      .gpio_pull_dn_o(gpd), .mode_o(mode));
   hvm_divider_model u_pm (.switch_i(sw), .sense_i(sense), .drv_i(pin_o), .oe_n_i(oe_n),
      .pin_o(pin_i), .adc_o());

   // free-running bench clock
   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end

   // hang guard, well above the few hundred cycles the run needs
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 5000) begin
         errors++;
         give_verdict();
      end
   end

   task give_verdict();
      if (errors == 0 && samples_checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : give_verdict

   task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask : check

   // one classic cycle; entered just after a rising edge
   task wb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                output logic [31:0] r);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      // wait as long as the slave needs; only the hang guard ends a stuck run
      do begin
         @(posedge clk_i);
      end while (ack !== 1'b1);
      r = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(posedge clk_i);
   endtask : wb_xfer

   initial begin
      rst_i = 1'b1;
      {cyc, stb, we, sense, fail, fsafe} = 6'h00;
      ce = 1'b1;
      adr = 8'h00;
      wdat = 32'h0;
      // sense, write, address, data, read mask, expected read
      rows = '{'{1'b0,1'b0,8'h00,8'h00,8'hFF,8'h00},
         '{1'b0,1'b0,8'h08,8'h00,8'hFF,8'h01}, '{1'b0,1'b0,8'h0C,8'h00,8'hFF,8'h01},
         '{1'b1,1'b0,8'h18,8'h00,8'h01,8'h01}, '{1'b1,1'b1,8'h18,8'h03,8'h00,8'h00},
         '{1'b1,1'b1,8'h00,8'h01,8'h00,8'h00}, '{1'b1,1'b0,8'h00,8'h00,8'hFF,8'h00},
         '{1'b1,1'b0,8'h14,8'h00,8'h01,8'h01}, '{1'b1,1'b1,8'h14,8'h01,8'h00,8'h00},
         '{1'b1,1'b1,8'h08,8'h00,8'h00,8'h00}, '{1'b1,1'b1,8'h00,8'h01,8'h00,8'h00},
         '{1'b1,1'b0,8'h14,8'h00,8'hFF,8'h02}, '{1'b0,1'b0,8'h18,8'h00,8'h03,8'h00},
         '{1'b0,1'b1,8'h08,8'h02,8'h00,8'h00}, '{1'b0,1'b0,8'h08,8'h00,8'hFF,8'h00},
         '{1'b0,1'b0,8'h14,8'h00,8'h01,8'h01}, '{1'b0,1'b1,8'h14,8'h01,8'h00,8'h00},
         '{1'b0,1'b1,8'h10,8'h02,8'h00,8'h00}, '{1'b0,1'b0,8'h10,8'h00,8'hFF,8'h02},
         '{1'b0,1'b1,8'h00,8'h03,8'h00,8'h00}, '{1'b0,1'b0,8'h00,8'h00,8'hFF,8'h03},
         '{1'b0,1'b0,8'h1C,8'h00,8'hFF,8'h00}, '{1'b0,1'b1,8'h04,8'h01,8'h00,8'h00},
         '{1'b0,1'b0,8'h14,8'h00,8'h02,8'h00}, '{1'b0,1'b0,8'h00,8'h00,8'h01,8'h01},
         '{1'b0,1'b1,8'h04,8'h00,8'h00,8'h00}, '{1'b0,1'b0,8'h14,8'h00,8'h02,8'h02},
         '{1'b0,1'b1,8'h04,8'h02,8'h00,8'h00}, '{1'b0,1'b0,8'h14,8'h00,8'h01,8'h01},
         '{1'b0,1'b0,8'h04,8'h00,8'hFF,8'h01}};
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      check("switch_reset", {31'h0, sw}, 32'h0);
      // pin keeps its fail output role before measuring
      fail <= 1'b1;
      repeat (2) @(posedge clk_i);
      check("fo_drive", {31'h0, oe_n}, 32'h0);
      fail <= 1'b0;
      // register rows; sense settles before each access so edges reach status
      foreach (rows[i]) begin
         sense <= rows[i].sense;
         repeat (3) @(posedge clk_i);
         wb_xfer(rows[i].we, rows[i].adr, {24'h0, rows[i].wd}, rd);
         if (!rows[i].we) check($sformatf("row %0d", i), rd & {24'h0, rows[i].mask},
            {24'h0, rows[i].exp});
      end
      // fail-safe in mid-measurement with a failure asking for the pin
      fail <= 1'b1;
      fsafe <= 1'b1;
      repeat (3) @(posedge clk_i);
      check("switch_fs", {31'h0, sw}, 32'h0);
      check("mode_fs", {27'h0, mode}, 32'h10);
      check("pin_fs", {31'h0, oe_n}, 32'h1);
      wb_xfer(1'b0, 8'h00, 32'h0, rd);
      check("ctrl_fs", rd & 32'h1, 32'h1);
      fsafe <= 1'b0;
      n = 0;
      while (sw !== 1'b1 && n < 20) begin
         @(posedge clk_i);
         n++;
      end
      check("switch_back", {31'h0, sw}, 32'h1);
      // clock enable low freezes all state, even against a fail-safe request
      ce <= 1'b0;
      fsafe <= 1'b1;
      repeat (3) @(posedge clk_i);
      check("mode_frozen", {27'h0, mode}, 32'h01);
      check("switch_frozen", {31'h0, sw}, 32'h1);
      ce <= 1'b1;
      fsafe <= 1'b0;
      // pull-up is configured, but measuring keeps every pull off
      check("pulls_meas", {29'h0, pu, pd, gpd}, 32'h0);
      wb_xfer(1'b1, 8'h00, 32'h0, rd);
      repeat (2) @(posedge clk_i);
      check("pulls_back", {29'h0, pu, pd, gpd}, 32'h4);
      check("switch_off", {31'h0, sw}, 32'h0);
      // second reset in mid-run with a failure still asking for the pin
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      check("outs_rst2", {28'h0, sw, pu, pd, gpd}, 32'h0);
      repeat (2) @(posedge clk_i);
      check("fo_back", {30'h0, pin_o, oe_n}, 32'h0);
      wb_xfer(1'b0, 8'h08, 32'h0, rd);
      check("gpio_rst2", rd, 32'h1);
      give_verdict();
   end
endmodule : tb
